// ==== dmc_pkg.sv ====
// constants and types shared by the dsp mac coprocessor files
package dmc_pkg;
    localparam int ACC_W = 40;
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int HI_W = ACC_W - WORD_W;
    localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
    localparam logic ACCESS_EN_RESET = 1'b0;
    // field positions of the multiply-with-internal-accumulate format
    localparam int COND_MSB = 31;
    localparam int COND_LSB = 28;
    localparam int FIXED_MSB = 27;
    localparam int FIXED_LSB = 20;
    localparam int OPC_MSB = 19;
    localparam int OPC_LSB = 16;
    localparam int MULR_MSB = 15;
    localparam int MULR_LSB = 12;
    localparam int ZERO_MSB = 11;
    localparam int ZERO_LSB = 8;
    localparam int ACCSEL_MSB = 7;
    localparam int ACCSEL_LSB = 5;
    localparam int ONE_BIT = 4;
    localparam int MCND_MSB = 3;
    localparam int MCND_LSB = 0;
    localparam int SEL_MCND_BIT = 17;
    localparam int SEL_MULR_BIT = 16;
    localparam int ENABLE_BIT = 0;
    localparam logic [7:0] FIXED_CODE = 8'he2;
    localparam logic [3:0] ZERO_CODE = 4'h0;
    localparam logic [2:0] ACC_ZERO = 3'h0;
    localparam logic [3:0] OPC_WORD = 4'h0;
    localparam logic [3:0] OPC_PACKED = 4'h8;
    localparam logic [1:0] OPC_SEL_TOP = 2'h3;
    // condition flags as n z c v, bit 3 down to bit 0
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 0;

    typedef enum logic [1:0] {
        MAC_WORD = 2'b00,
        MAC_PACKED = 2'b01,
        MAC_SELECT = 2'b11
    } dmc_mac_mode_t;

    function automatic logic cond_pass(input logic [3:0] cond, input logic [3:0] f);
        logic p;
        p = 1'b0;
        case (cond[3:1])
            3'h0: p = f[FLAG_Z];
            3'h1: p = f[FLAG_C];
            3'h2: p = f[FLAG_N];
            3'h3: p = f[FLAG_V];
            3'h4: p = f[FLAG_C] & ~f[FLAG_Z];
            3'h5: p = (f[FLAG_N] == f[FLAG_V]);
            3'h6: p = (f[FLAG_N] == f[FLAG_V]) & ~f[FLAG_Z];
            default: p = 1'b1;
        endcase
        // the never encoding is not passed by anything
        if (cond == 4'hf) begin
            return 1'b0;
        end
        if (cond[3:1] == 3'h7) begin
            return 1'b1;
        end
        return p ^ cond[0];
    endfunction
endpackage

// ==== dmc_mac_if.sv ====
// carrier between the decoder and the multiply-add datapath
`timescale 1ns/1ps
interface dmc_mac_if;
    dmc_pkg::dmc_mac_mode_t mode;
    logic [dmc_pkg::WORD_W-1:0] multiplier;
    logic [dmc_pkg::WORD_W-1:0] multiplicand;
    logic sel_hi_multiplicand;
    logic sel_hi_multiplier;
    logic [dmc_pkg::ACC_W-1:0] addend;
    logic [dmc_pkg::ACC_W-1:0] sum;
    modport ctrl (
        output mode,
        output multiplier,
        output multiplicand,
        output sel_hi_multiplicand,
        output sel_hi_multiplier,
        output addend,
        input sum
    );
    modport unit (
        input mode,
        input multiplier,
        input multiplicand,
        input sel_hi_multiplicand,
        input sel_hi_multiplier,
        input addend,
        output sum
    );
endinterface

// ==== dmc_mac_unit.sv ====
// combinational signed multiply-add datapath for the internal accumulator
`timescale 1ns/1ps
module dmc_mac_unit (
    dmc_mac_if.unit mac
);
    localparam int W = dmc_pkg::WORD_W;
    localparam int H = dmc_pkg::HALF_W;
    localparam int A = dmc_pkg::ACC_W;

    logic signed [2*W-1:0] word_prod;
    logic signed [W-1:0] lo_prod;
    logic signed [W-1:0] hi_prod;
    logic signed [W-1:0] sel_prod;
    logic signed [H-1:0] op_mcnd;
    logic signed [H-1:0] op_mulr;
    logic [A-1:0] delta;

    // every operand is signed, there is no unsigned mode
    assign word_prod = $signed(mac.multiplier) * $signed(mac.multiplicand);
    assign lo_prod = $signed(mac.multiplicand[H-1:0]) * $signed(mac.multiplier[H-1:0]);
    assign hi_prod = $signed(mac.multiplicand[W-1:H]) * $signed(mac.multiplier[W-1:H]);
    assign op_mcnd = mac.sel_hi_multiplicand ? mac.multiplicand[W-1:H]
                                             : mac.multiplicand[H-1:0];
    assign op_mulr = mac.sel_hi_multiplier ? mac.multiplier[W-1:H]
                                           : mac.multiplier[H-1:0];
    assign sel_prod = op_mcnd * op_mulr;

    always_comb begin
        case (mac.mode)
            dmc_pkg::MAC_WORD: delta = word_prod[A-1:0];
            // products sign-extended before the add so the pair cannot overflow 32 bits
            dmc_pkg::MAC_PACKED: delta = A'(lo_prod) + A'(hi_prod);
            dmc_pkg::MAC_SELECT: delta = A'(sel_prod);
            default: delta = '0;
        endcase
    end

    // plain 40-bit add, wraps without saturation or overflow flag
    assign mac.sum = mac.addend + delta;
endmodule

// ==== dmc_coproc.sv ====
// dsp mac coprocessor top: decode, access gating, accumulator and transfers
// Contract
// - one shared 40-bit internal accumulator
// - products accumulate internally, not into registers
// - accumulator written from and read to core
// - accepted in any mode when enable set
// - disabled access traps undefined, accumulator kept
// - only privileged writes change the enable
// - condition code from bits 31 to 28
// - register-transfer space; multiplier 15:12, multiplicand 3:0
// - operation type from bits 19 to 16
// - 0000 word, 1000 packed, others unpredictable
// - accumulator select from bits 7 to 5
// - only accumulator zero implemented
// - word op multiplies and adds to accumulator
// - operands always signed two's complement
// - update only when condition passes
// - packed op adds two sign-extended halfword products
// - bit 17 multiplicand half, bit 16 multiplier half
// - core condition flags never updated
`timescale 1ns/1ps
module dmc_coproc (
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic INSTR_VALID_IN,
    input wire logic [31:0] INSTR_IN,
    input wire logic [3:0] FLAGS_IN,
    input wire logic [31:0] MULTIPLIER_IN,
    input wire logic [31:0] MULTIPLICAND_IN,
    input wire logic ACC_WRITE_IN,
    input wire logic [31:0] ACC_WRITE_LO_IN,
    input wire logic [31:0] ACC_WRITE_HI_IN,
    input wire logic ACC_READ_IN,
    input wire logic ACCESS_WRITE_IN,
    input wire logic [31:0] ACCESS_DATA_IN,
    input wire logic PRIVILEGED_IN,
    output logic DONE_OUT,
    output logic UNDEF_OUT,
    output logic READ_VALID_OUT,
    output logic [31:0] ACC_READ_LO_OUT,
    output logic [31:0] ACC_READ_HI_OUT,
    output logic ACCESS_EN_OUT
);
    localparam int A = dmc_pkg::ACC_W;
    localparam int W = dmc_pkg::WORD_W;

    dmc_mac_if mac ();

    logic access_en_q;
    logic [A-1:0] acc_q;
    logic done_q;
    logic undef_q;
    logic read_valid_q;
    logic [W-1:0] read_lo_q;
    logic [W-1:0] read_hi_q;
    logic is_mac;
    logic [3:0] opc;
    logic opc_ok;
    logic mac_fire;
    logic xfer_req;
    logic any_req;

    // format lies in the coprocessor register-transfer space
    assign is_mac = INSTR_VALID_IN
        && (INSTR_IN[dmc_pkg::FIXED_MSB:dmc_pkg::FIXED_LSB] == dmc_pkg::FIXED_CODE)
        && (INSTR_IN[dmc_pkg::ZERO_MSB:dmc_pkg::ZERO_LSB] == dmc_pkg::ZERO_CODE)
        && INSTR_IN[dmc_pkg::ONE_BIT];
    assign opc = INSTR_IN[dmc_pkg::OPC_MSB:dmc_pkg::OPC_LSB];
    // unlisted encodings are unpredictable; here 11xx does a selected halfword multiply, the rest do nothing
    assign opc_ok = (opc == dmc_pkg::OPC_WORD) || (opc == dmc_pkg::OPC_PACKED)
        || (opc[3:2] == dmc_pkg::OPC_SEL_TOP);
    // a nonzero accumulator select is unsupported and leaves acc alone
    assign mac_fire = is_mac && access_en_q && opc_ok
        && (INSTR_IN[dmc_pkg::ACCSEL_MSB:dmc_pkg::ACCSEL_LSB] == dmc_pkg::ACC_ZERO)
        && dmc_pkg::cond_pass(INSTR_IN[dmc_pkg::COND_MSB:dmc_pkg::COND_LSB], FLAGS_IN);
    assign xfer_req = ACC_WRITE_IN || ACC_READ_IN;
    assign any_req = is_mac || xfer_req;

    always_comb begin
        if (opc == dmc_pkg::OPC_WORD) begin
            mac.mode = dmc_pkg::MAC_WORD;
        end else if (opc == dmc_pkg::OPC_PACKED) begin
            mac.mode = dmc_pkg::MAC_PACKED;
        end else begin
            mac.mode = dmc_pkg::MAC_SELECT;
        end
    end
    // register values arrive already read by the core from the numbered fields
    assign mac.multiplier = MULTIPLIER_IN;
    assign mac.multiplicand = MULTIPLICAND_IN;
    assign mac.sel_hi_multiplicand = INSTR_IN[dmc_pkg::SEL_MCND_BIT];
    assign mac.sel_hi_multiplier = INSTR_IN[dmc_pkg::SEL_MULR_BIT];
    assign mac.addend = acc_q;

    dmc_mac_unit u_mac (
        .mac(mac)
    );

    // enable bit is changed by privileged writes only
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            access_en_q <= dmc_pkg::ACCESS_EN_RESET;
        end else if (ACCESS_WRITE_IN && PRIVILEGED_IN) begin
            access_en_q <= ACCESS_DATA_IN[dmc_pkg::ENABLE_BIT];
        end
    end

    // single accumulator, reset to zero though software must load it
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            acc_q <= dmc_pkg::ACC_RESET;
        end else if (mac_fire) begin
            acc_q <= mac.sum;
        end else if (ACC_WRITE_IN && access_en_q) begin
            acc_q <= {ACC_WRITE_HI_IN[dmc_pkg::HI_W-1:0], ACC_WRITE_LO_IN};
        end
    end

    // read returns low word and the top byte sign-extended into a word
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            read_valid_q <= 1'b0;
            read_lo_q <= '0;
            read_hi_q <= '0;
        end else begin
            read_valid_q <= ACC_READ_IN && access_en_q;
            if (ACC_READ_IN && access_en_q) begin
                read_lo_q <= acc_q[W-1:0];
                read_hi_q <= W'($signed(acc_q[A-1:W]));
            end
        end
    end

    // any request while disabled traps, the accumulator paths above are gated
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            undef_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            undef_q <= any_req && !access_en_q;
            done_q <= any_req && access_en_q;
        end
    end

    // no flag output exists: the core flags are never written from here
    assign DONE_OUT = done_q;
    assign UNDEF_OUT = undef_q;
    assign READ_VALID_OUT = read_valid_q;
    assign ACC_READ_LO_OUT = read_lo_q;
    assign ACC_READ_HI_OUT = read_hi_q;
    assign ACCESS_EN_OUT = access_en_q;
endmodule

// ==== dmc_coproc_props.sv ====
// port assertions for the dsp mac coprocessor
`timescale 1ns/1ps
module dmc_coproc_props (
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic INSTR_VALID_IN,
    input wire logic [31:0] INSTR_IN,
    input wire logic ACC_WRITE_IN,
    input wire logic ACC_READ_IN,
    input wire logic ACCESS_WRITE_IN,
    input wire logic [31:0] ACCESS_DATA_IN,
    input wire logic PRIVILEGED_IN,
    input wire logic DONE_OUT,
    input wire logic UNDEF_OUT,
    input wire logic READ_VALID_OUT,
    input wire logic [31:0] ACC_READ_LO_OUT,
    input wire logic [31:0] ACC_READ_HI_OUT,
    input wire logic ACCESS_EN_OUT
);
    logic rec;
    // only the fixed bits of the format make a word ours
    assign rec = INSTR_VALID_IN && INSTR_IN[27:20] == 8'he2 && INSTR_IN[11:8] == 4'h0
        && INSTR_IN[4];
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    property p_en_done; rec && ACCESS_EN_OUT |=> DONE_OUT && !UNDEF_OUT; endproperty
    a_en_done: assert property (p_en_done) else $error("enabled op not done");
    property p_dis; (rec || ACC_READ_IN || ACC_WRITE_IN) && !ACCESS_EN_OUT
        |=> UNDEF_OUT && !DONE_OUT && !READ_VALID_OUT; endproperty
    a_dis: assert property (p_dis) else $error("disabled op not trapped");
    property p_rd; ACC_READ_IN && ACCESS_EN_OUT |=> READ_VALID_OUT; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_priv; ACCESS_WRITE_IN && PRIVILEGED_IN |=> ACCESS_EN_OUT == $past(ACCESS_DATA_IN[0]);
    endproperty
    a_priv: assert property (p_priv) else $error("enable not written");
    property p_unpriv; ACCESS_WRITE_IN && !PRIVILEGED_IN |=> $stable(ACCESS_EN_OUT); endproperty
    a_unpriv: assert property (p_unpriv) else $error("unprivileged write took");
    property p_none; !rec && !ACC_READ_IN && !ACC_WRITE_IN |=> !DONE_OUT && !UNDEF_OUT;
    endproperty
    a_none: assert property (p_none) else $error("foreign word answered");
    property p_hold; !ACC_READ_IN |=> $stable(ACC_READ_LO_OUT) && $stable(ACC_READ_HI_OUT);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_ext; READ_VALID_OUT |-> ACC_READ_HI_OUT[31:8] == {24{ACC_READ_HI_OUT[7]}};
    endproperty
    a_ext: assert property (p_ext) else $error("high word not extended");
endmodule
bind dmc_coproc dmc_coproc_props u_props (.CLK_IN, .RSTN_IN, .INSTR_VALID_IN, .INSTR_IN,
    .ACC_WRITE_IN, .ACC_READ_IN, .ACCESS_WRITE_IN, .ACCESS_DATA_IN, .PRIVILEGED_IN, .DONE_OUT,
    .UNDEF_OUT, .READ_VALID_OUT, .ACC_READ_LO_OUT, .ACC_READ_HI_OUT, .ACCESS_EN_OUT);

// ==== dmc_core_model.sv ====
// core register file model feeding the operands an instruction names
`timescale 1ns/1ps
module dmc_core_model (
    input wire logic [31:0] instr_in,
    output logic [31:0] mulr_out,
    output logic [31:0] mcnd_out
);
    logic [31:0] regs [16];
    // operands are read in the issue cycle, as the core does
    assign mulr_out = regs[instr_in[15:12]];
    assign mcnd_out = regs[instr_in[3:0]];
endmodule

// ==== testbench.sv ====
// self-checking bench for the dsp mac coprocessor
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic pv = 1'b0;
    logic [3:0] stb = 4'h0;
    logic [3:0] fl = 4'h0;
    logic [31:0] ins = 32'h0000_0000;
    logic [31:0] alo = 32'h0000_0000;
    logic [31:0] ahi = 32'h0000_0000;
    logic [31:0] xd = 32'h0000_0000;
    logic [31:0] mulr, mcnd, rlo, rhi;
    logic done, undef, rv, en;
    logic [39:0] acc;
    int n_fail = 0;
    int n_checks = 0;
    always #2 clk = ~clk;
    dmc_core_model core (.instr_in(ins), .mulr_out(mulr), .mcnd_out(mcnd));
    dmc_coproc dut (.CLK_IN(clk), .RSTN_IN(rstn), .INSTR_VALID_IN(stb[3]), .INSTR_IN(ins),
        .FLAGS_IN(fl), .MULTIPLIER_IN(mulr), .MULTIPLICAND_IN(mcnd), .ACC_WRITE_IN(stb[2]),
        .ACC_WRITE_LO_IN(alo), .ACC_WRITE_HI_IN(ahi), .ACC_READ_IN(stb[1]),
        .ACCESS_WRITE_IN(stb[0]), .ACCESS_DATA_IN(xd), .PRIVILEGED_IN(pv), .DONE_OUT(done),
        .UNDEF_OUT(undef), .READ_VALID_OUT(rv), .ACC_READ_LO_OUT(rlo), .ACC_READ_HI_OUT(rhi),
        .ACCESS_EN_OUT(en));
    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] mk(input logic [3:0] c, input logic [3:0] op,
        input logic [2:0] a);
        return {c, 8'he2, op, 4'h3, 4'h0, a, 1'b1, 4'h9};
    endfunction
    // expected product, worked independently of the design
    function automatic logic [39:0] prod(input logic [3:0] op, input logic [31:0] s,
        input logic [31:0] m);
        logic signed [63:0] w;
        logic signed [39:0] p, q;
        logic signed [15:0] x, y;
        w = $signed(s) * $signed(m);
        if (op == 4'h0) return w[39:0];
        if (op[3:2] != 2'b11 && op != 4'h8) return 40'h0;
        x = op[1] ? m[31:16] : m[15:0];
        y = op[0] ? s[31:16] : s[15:0];
        p = x * y;
        if (op != 4'h8) return p;
        x = m[31:16];
        y = s[31:16];
        // product formed at full width before the add so no high bits are lost
        q = x * y;
        return p + q;
    endfunction
    // caller waits the edge first; strobes drop one cycle later
    task automatic req(input logic [3:0] s);
        stb <= s;
        @(posedge clk);
        stb <= 4'h0;
        #1;
    endtask
    task automatic mac(input logic [31:0] w);
        @(posedge clk);
        ins <= w;
        req(4'h8);
    endtask
    task automatic setx(input logic p, input logic v);
        @(posedge clk);
        pv <= p;
        xd <= {31'h0000_0000, v};
        req(4'h1);
    endtask
    task automatic wacc(input logic [39:0] v);
        @(posedge clk);
        alo <= v[31:0];
        ahi <= {24'hFF_FFFF, v[39:32]};
        req(4'h4);
        chk("write done", done, 40'h1);
    endtask
    task automatic rd(input logic [39:0] e);
        @(posedge clk);
        req(4'h2);
        chk("read valid", rv, 40'h1);
        chk("accumulator", {rhi[7:0], rlo}, e);
        chk("read high", rhi[31:8], {24{e[39]}});
    endtask
    task automatic rdx;
        @(posedge clk);
        req(4'h2);
        chk("read trap", {undef, rv}, 40'h2);
    endtask
    task automatic t_off;
        rdx;
        setx(1'b0, 1'b1);
        chk("enable", en, 40'h0);
        setx(1'b1, 1'b1);
        chk("enable", en, 40'h1);
        rd(40'h00_0000_0000);
        $display("access test done");
    endtask
    task automatic t_ops;
        logic [3:0] ops [7] = '{4'h0, 4'h8, 4'hc, 4'hd, 4'he, 4'hf, 4'h1};
        acc = 40'h00_0000_0000;
        wacc(acc);
        foreach (ops[i]) begin
            mac(mk(4'he, ops[i], 3'h0));
            chk("mac done", done, 40'h1);
            acc = acc + prod(ops[i], core.regs[3], core.regs[9]);
            rd(acc);
        end
        $display("mac test done");
    endtask
    task automatic t_cond;
        wacc(40'h80_0000_0000);
        mac(mk(4'h0, 4'h0, 3'h0));
        chk("failed cond done", done, 40'h1);
        mac(mk(4'he, 4'h0, 3'h1));
        mac(mk(4'he, 4'h0, 3'h0) & 32'hFFFF_FFEF);
        chk("foreign word", {undef, done}, 40'h0);
        rd(40'h80_0000_0000);
        mac(mk(4'h1, 4'h0, 3'h0));
        acc = 40'h80_0000_0000 + prod(4'h0, core.regs[3], core.regs[9]);
        rd(acc);
        // zero flag set, so the equal condition now passes
        @(posedge clk);
        fl <= 4'h4;
        mac(mk(4'h0, 4'h0, 3'h0));
        acc = acc + prod(4'h0, core.regs[3], core.regs[9]);
        rd(acc);
        $display("condition test done");
    endtask
    task automatic t_dis;
        setx(1'b1, 1'b0);
        chk("enable", en, 40'h0);
        mac(mk(4'he, 4'h0, 3'h0));
        chk("mac trap", {undef, done}, 40'h2);
        rdx;
        @(posedge clk);
        alo <= 32'hFFFF_FFFF;
        req(4'h4);
        chk("write trap", {undef, done}, 40'h2);
        setx(1'b1, 1'b1);
        rd(acc);
        $display("disable test done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        core.regs[3] = 32'h8001_FFFE;
        core.regs[9] = 32'h0003_7FFF;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_off;
        t_ops;
        t_cond;
        t_dis;
        end_sim;
    end
    // the tests need under a hundred cycles; this leaves wide margin
    initial begin
        repeat (2000) @(posedge clk);
        n_fail++;
        end_sim;
    end
endmodule
